/* verif/epil_pin_source.sv */
// external interrupt source model driving the active-low pin
`timescale 1ns/10ps
`default_nettype none

module epil_pin_source (
    input wire logic pclk,
    input wire logic drive_low,
    input wire logic [3:0] lag,
    output logic irq_pin_n
);
    // ========================================
    // pin driver
    logic [3:0] cnt = 4'h0;
    // released pin floats to the pull-up level
    logic pin_q = 1'b1;
    assign irq_pin_n = pin_q;
    // lag lets the source answer promptly or slowly
    always @(posedge pclk) begin
        if (pin_q == !drive_low) begin
            cnt <= 4'h0;
        end else if (cnt >= lag) begin
            pin_q <= !drive_low;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : epil_pin_source

`default_nettype wire

/* verif/testbench.sv */
// self-checking testbench for the external pin interrupt latch
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import epil_pkg::*;
    localparam logic [31:0] MD = 32'h1 << EPIL_BIT_MODE;
    localparam logic [31:0] MK = 32'h1 << EPIL_BIT_MASK;
    localparam logic [31:0] AK = 32'h1 << EPIL_BIT_ACK;
    localparam logic [31:0] PD = 32'h1 << EPIL_BIT_PEND;
    logic pclk, presetn, psel, penable, pwrite, drive_low, slv;
    logic vector_fetch, break_state, permit, pready, pslverr;
    logic pin_n, cpu_irq_request, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vhi, vlo;
    logic [3:0] lag;
    int err_count, n_compared;

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    epil_pin_source u_epil_pin_source (.pclk(pclk),
        .drive_low(drive_low), .lag(lag), .irq_pin_n(pin_n));

    epil_top u_epil_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_pin_n(pin_n),
        .vector_fetch(vector_fetch), .break_state(break_state),
        .break_clear_permit_bit(permit),
        .cpu_irq_request(cpu_irq_request), .vector_hi_addr(vhi),
        .vector_lo_addr(vlo), .irq(irq));

    // ========================================
    // shared tasks
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] act, input logic [31:0] exp);
        n_compared++;
        if (act !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, act, exp);
        end
    endtask : chk

    // no fixed answer time is assumed: wait on pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("unexpected at %0t: no pready", $time);
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task pin(input logic low);
        int n;
        n = 0;
        @(posedge pclk);
        drive_low <= low;
        while (pin_n !== !low && n < 20) begin
            @(posedge pclk);
            n++;
        end
        repeat (6) @(posedge pclk);
    endtask : pin

    // the cpu vectors only on a standing request, global mask clear
    task fetch;
        chk(cpu_irq_request, 1'b1);
        @(posedge pclk);
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : fetch

    // ========================================
    // scenarios
    task t_reset;
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(vhi, 16'hfffa);
        chk(vlo, 16'hfffb);
        apb(1'b0, 12'h00c, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task t_edge;
        apb(1'b1, EPIL_OFF_MASK, 32'h1);
        pin(1'b1);
        chk(cpu_irq_request, 1'b1);
        chk(irq, 1'b1);
        fetch;
        chk(cpu_irq_request, 1'b0);
        apb(1'b0, EPIL_OFF_STAT, 32'h0);
        chk(rd, 32'h3);
        pin(1'b0);
        apb(1'b1, EPIL_OFF_MASK, 32'h0);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, EPIL_OFF_STAT, 32'h3);
        apb(1'b0, EPIL_OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        $display("test edge done");
    endtask : t_edge

    task t_mask;
        apb(1'b1, EPIL_OFF_CTRL, MK);
        pin(1'b1);
        chk(cpu_irq_request, 1'b0);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, MK | PD);
        apb(1'b1, EPIL_OFF_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(cpu_irq_request, 1'b1);
        apb(1'b1, EPIL_OFF_CTRL, AK);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        pin(1'b0);
        pin(1'b1);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, PD);
        fetch;
        pin(1'b0);
        $display("test mask done");
    endtask : t_mask

    task t_level;
        apb(1'b1, EPIL_OFF_CTRL, MD);
        lag <= 4'h5;
        pin(1'b1);
        apb(1'b1, EPIL_OFF_CTRL, MD | MK | AK);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, MD | MK | PD);
        chk(cpu_irq_request, 1'b0);
        pin(1'b0);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, MD | MK);
        apb(1'b1, EPIL_OFF_CTRL, MD);
        lag <= 4'h0;
        pin(1'b1);
        pin(1'b0);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, MD | PD);
        fetch;
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, MD);
        apb(1'b1, EPIL_OFF_CTRL, 32'h0);
        $display("test level done");
    endtask : t_level

    task t_break;
        pin(1'b1);
        pin(1'b0);
        @(posedge pclk);
        break_state <= 1'b1;
        apb(1'b1, EPIL_OFF_CTRL, AK);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, PD);
        permit <= 1'b1;
        apb(1'b1, EPIL_OFF_CTRL, AK);
        break_state <= 1'b0;
        permit <= 1'b0;
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("test break done");
    endtask : t_break

    task t_rst;
        apb(1'b1, EPIL_OFF_CTRL, MD | MK);
        pin(1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, EPIL_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(cpu_irq_request, 1'b0);
        pin(1'b0);
        $display("test mid reset done");
    endtask : t_rst

    // ========================================
    // main sequence and watchdog
    initial begin
        {psel, penable, pwrite, drive_low, vector_fetch} = 5'h0;
        {break_state, permit, presetn} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lag = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_edge;
        t_mask;
        t_level;
        t_break;
        t_rst;
        tally_and_finish;
    end

    initial begin
        repeat (4000) @(posedge pclk);
        err_count++;
        $display("unexpected at %0t: watchdog", $time);
        tally_and_finish;
    end
endmodule : testbench

`default_nettype wire

/* verilog/epil_pin_sync.sv */
// pin synchroniser and falling edge detector for the interrupt pin
`timescale 1ns/10ps
`default_nettype none

module epil_pin_sync
    import epil_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_n,
    output var epil_pin_s pin
);

    // ========================================
    // two flop synchroniser, stage one feeds only stage two
    logic meta;
    logic sync;
    logic last;
    logic [1:0] warm;

    // pin idles high (pullup), so reset to one avoids a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
            warm <= 2'h0;
        end else begin
            meta <= pin_n;
            sync <= meta;
            last <= sync;
            if (warm != 2'h3) begin
                warm <= warm + 2'h1;
            end
        end
    end

    // falling edge: one sample high followed by one sample low
    // no edge until last holds a real sample: a pin low through reset
    // must not raise a request once reset is released
    assign pin.level = sync;
    assign pin.fall = (warm == 2'h3) & last & ~sync; // R18 R4

endmodule : epil_pin_sync

`default_nettype wire

/* verilog/epil_pkg.sv */
// package for the external pin interrupt latch: map, fields, types
package epil_pkg;

    // ========================================
    // register map (byte addresses, apb word aligned)
    localparam logic [11:0] EPIL_OFF_CTRL = 12'h000;
    localparam logic [11:0] EPIL_OFF_STAT = 12'h004;
    localparam logic [11:0] EPIL_OFF_MASK = 12'h008;

    // ========================================
    // external_interrupt_status_control fields
    localparam int EPIL_BIT_MODE = 0;
    localparam int EPIL_BIT_MASK = 1;
    localparam int EPIL_BIT_ACK = 2;
    localparam int EPIL_BIT_PEND = 3;

    // event status / event mask fields
    localparam int EPIL_EV_SET = 0;
    localparam int EPIL_EV_ACK = 1;
    localparam int EPIL_EV_W = 2;

    // ========================================
    // reset values
    localparam logic EPIL_RST_MODE = 1'b0;
    localparam logic EPIL_RST_MASK = 1'b0;
    localparam logic [EPIL_EV_W-1:0] EPIL_RST_EV = 2'h0;
    localparam logic [31:0] EPIL_RST_RDATA = 32'h0000_0000;

    // vector locations fetched by the cpu for this interrupt
    localparam logic [15:0] EPIL_VEC_HI = 16'hfffa;
    localparam logic [15:0] EPIL_VEC_LO = 16'hfffb;

    // ========================================
    // types
    typedef enum logic [1:0] {
        EPIL_BUS_IDLE = 2'b00,
        EPIL_BUS_WAIT = 2'b01,
        EPIL_BUS_DONE = 2'b11
    } epil_bus_e;

    typedef struct packed {
        logic level;
        logic fall;
    } epil_pin_s;

    typedef struct packed {
        epil_bus_e phase;
        logic latch;
        logic ack_seen;
        logic mode;
        logic mask;
        logic [EPIL_EV_W-1:0] ev_stat;
        logic [EPIL_EV_W-1:0] ev_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_req;
        logic irq;
    } epil_state_s;

endpackage : epil_pkg

/* verilog/epil_top.sv */
// external pin interrupt latch with apb status/control registers
// Contract
// R1: a low on the pin sets the request latch per sensitivity
// R2: a vector fetch acknowledge clears the request latch
// R3: writing one to the acknowledge bit clears the latch like a fetch
// R4: reset clears the latch even while the pin is low
// R5: reset clears sensitivity, mask and acknowledge bits
// R6: edge-only mode: acknowledge clears the request at once
// R7: edge-and-level mode: clear needs acknowledge and pin high, any order
// R8: edge-and-level mode keeps request pending while pin stays low
// R9: mask bit set withholds the request from the cpu
// R10: pending flag shows the latch regardless of the mask
// R11: acknowledge bit is write-only and reads zero
// R12: software acknowledge leaves edge detection intact
// R13: taken request vectors through the dedicated high/low addresses
// R14: in break without permit, software acknowledge has no effect
// R15: with permit, break acknowledge clears and stays cleared
// R16: cpu global interrupt mask also blocks this request
// R17: software should mask in level mode to avoid repeats
// R18: pin synchronised; falling edge is one high then one low sample
`timescale 1ns/10ps
`default_nettype none

module epil_top
    import epil_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pin_n,
    input wire logic vector_fetch,
    input wire logic break_state,
    input wire logic break_clear_permit_bit,
    output logic cpu_irq_request,
    output logic [15:0] vector_hi_addr,
    output logic [15:0] vector_lo_addr,
    output logic irq
);

    // ========================================
    // pin front end
    epil_pin_s pin;

    epil_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(irq_pin_n),
        .pin(pin)
    );

    // ========================================
    // address decode helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] off);
        logic [ADDR_W-1:0] o;
        o = ADDR_W'(off);
        hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, EPIL_OFF_CTRL) | hit(a, EPIL_OFF_STAT)
               | hit(a, EPIL_OFF_MASK);
    endfunction : mapped

    // ========================================
    // state
    epil_state_s s;
    epil_state_s next_s;

    logic commit;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic sw_ack;
    logic ack;
    logic ack_any;
    logic latch_next;
    logic [EPIL_EV_W-1:0] ev;

    // a write takes effect only at the edge where pready is sampled high
    assign commit = psel & penable & s.pready;
    assign wr_ctrl = commit & pwrite & pstrb[0] & hit(paddr, EPIL_OFF_CTRL);
    assign wr_stat = commit & pwrite & pstrb[0] & hit(paddr, EPIL_OFF_STAT);
    assign wr_mask = commit & pwrite & pstrb[0] & hit(paddr, EPIL_OFF_MASK);

    // break protects the latch from software acknowledge unless the permit input is set
    assign sw_ack = wr_ctrl & pwdata[EPIL_BIT_ACK]
                  & ~(break_state & ~break_clear_permit_bit); // R3 R14 R15
    assign ack = vector_fetch | sw_ack; // R2
    assign ack_any = ack | s.ack_seen;

    always_comb begin
        if (s.mode) begin
            // level mode: needs both an acknowledge and the pin high
            latch_next = pin.fall
                       | (s.latch & ~(ack_any & pin.level)); // R7 R8
        end else begin
            latch_next = pin.fall | (s.latch & ~ack); // R1 R6 R12
        end
    end

    assign ev[EPIL_EV_SET] = latch_next & ~s.latch;
    assign ev[EPIL_EV_ACK] = ack & s.latch;

    always_comb begin
        next_s = s;
        next_s.latch = latch_next;
        // remember an acknowledge until the request drops or a new falling edge arrives
        if (!latch_next || pin.fall) begin
            next_s.ack_seen = 1'b0;
        end else if (ack) begin
            next_s.ack_seen = 1'b1;
        end
        if (wr_ctrl) begin
            next_s.mode = pwdata[EPIL_BIT_MODE];
            next_s.mask = pwdata[EPIL_BIT_MASK];
        end
        if (wr_mask) begin
            next_s.ev_mask = pwdata[EPIL_EV_W-1:0];
        end
        // new events win over a write-one clear in the same cycle
        if (wr_stat) begin
            next_s.ev_stat = (s.ev_stat & ~pwdata[EPIL_EV_W-1:0]) | ev;
        end else begin
            next_s.ev_stat = s.ev_stat | ev;
        end
        next_s.cpu_req = latch_next & ~next_s.mask; // R9
        next_s.irq = |(next_s.ev_stat & next_s.ev_mask);
        // apb: one wait cycle, read data captured while waiting
        next_s.pready = 1'b0;
        case (s.phase)
            EPIL_BUS_IDLE: begin
                if (psel && !penable) begin
                    next_s.phase = EPIL_BUS_WAIT;
                end
            end
            EPIL_BUS_WAIT: begin
                next_s.phase = EPIL_BUS_DONE;
                next_s.pready = 1'b1;
                next_s.pslverr = ~mapped(paddr);
                next_s.prdata = EPIL_RST_RDATA;
                if (!pwrite) begin
                    if (hit(paddr, EPIL_OFF_CTRL)) begin
                        next_s.prdata[EPIL_BIT_MODE] = s.mode;
                        next_s.prdata[EPIL_BIT_MASK] = s.mask;
                        next_s.prdata[EPIL_BIT_ACK] = 1'b0; // R11
                        next_s.prdata[EPIL_BIT_PEND] = s.latch; // R10
                    end else if (hit(paddr, EPIL_OFF_STAT)) begin
                        next_s.prdata[EPIL_EV_W-1:0] = s.ev_stat;
                    end else if (hit(paddr, EPIL_OFF_MASK)) begin
                        next_s.prdata[EPIL_EV_W-1:0] = s.ev_mask;
                    end
                end
            end
            EPIL_BUS_DONE: begin
                next_s.phase = EPIL_BUS_IDLE;
                next_s.pslverr = 1'b0;
                next_s.prdata = EPIL_RST_RDATA;
            end
            default: begin
                next_s.phase = EPIL_BUS_IDLE;
            end
        endcase
    end

    // reset clears latch and control bits whatever the pin does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.phase <= EPIL_BUS_IDLE;
            s.latch <= 1'b0; // R4
            s.ack_seen <= 1'b0;
            s.mode <= EPIL_RST_MODE; // R5
            s.mask <= EPIL_RST_MASK; // R5
            s.ev_stat <= EPIL_RST_EV;
            s.ev_mask <= EPIL_RST_EV;
            s.prdata <= EPIL_RST_RDATA;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.cpu_req <= 1'b0;
            s.irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // vector locations are fixed; held in flops so outputs are registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_hi_addr <= EPIL_VEC_HI; // R13
            vector_lo_addr <= EPIL_VEC_LO; // R13
        end else begin
            vector_hi_addr <= EPIL_VEC_HI;
            vector_lo_addr <= EPIL_VEC_LO;
        end
    end

    // the cpu's own global mask still gates cpu_irq_request downstream
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign cpu_irq_request = s.cpu_req; // R16
    assign irq = s.irq;

    // ========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_ctrl_done;
    assign rd_ctrl_done = commit & ~pwrite & hit(paddr, EPIL_OFF_CTRL);

    property p_fall_sets;
        pin.fall |=> s.latch;
    endproperty
    a_fall_sets: assert property (p_fall_sets) // R1
        else $error("falling edge did not set latch");

    property p_fetch_clears;
        !s.mode && vector_fetch && !pin.fall |=> !s.latch;
    endproperty
    a_fetch_clears: assert property (p_fetch_clears) // R2
        else $error("vector fetch did not clear latch");

    property p_edge_sw_ack;
        !s.mode && sw_ack && !pin.fall |=> !s.latch;
    endproperty
    a_edge_sw_ack: assert property (p_edge_sw_ack) // R6
        else $error("edge mode ack did not clear latch");

    property p_level_hold;
        s.mode && s.latch && !pin.level |=> s.latch;
    endproperty
    a_level_hold: assert property (p_level_hold) // R8
        else $error("level mode request dropped while pin low");

    property p_level_release;
        s.mode && s.latch && s.ack_seen && pin.level && !pin.fall
            |=> !s.latch && !cpu_irq_request;
    endproperty
    a_level_release: assert property (p_level_release) // R7
        else $error("level mode request not released");

    property p_mask_gate;
        cpu_irq_request == (s.latch && !s.mask);
    endproperty
    a_mask_gate: assert property (p_mask_gate) // R9
        else $error("cpu request does not follow latch and mask");

    property p_pend_read;
        rd_ctrl_done |-> prdata[EPIL_BIT_PEND] == $past(s.latch)
                         && prdata[EPIL_BIT_ACK] == 1'b0;
    endproperty
    a_pend_read: assert property (p_pend_read) // R10 R11
        else $error("control read shows wrong pending or ack bit");

    property p_ack_edge;
        wr_ctrl && pwdata[EPIL_BIT_ACK] && pin.fall |=> s.latch;
    endproperty
    a_ack_edge: assert property (p_ack_edge) // R12
        else $error("edge lost during software acknowledge");

    property p_break_protect;
        wr_ctrl && pwdata[EPIL_BIT_ACK] && break_state
            && !break_clear_permit_bit && !vector_fetch && s.latch
            |=> s.latch;
    endproperty
    a_break_protect: assert property (p_break_protect) // R14
        else $error("software ack cleared latch in protected break");

    property p_vector;
        vector_hi_addr == EPIL_VEC_HI && vector_lo_addr == EPIL_VEC_LO;
    endproperty
    a_vector: assert property (p_vector) // R13
        else $error("vector addresses wrong");

    property p_bus_wait;
        psel && !penable && s.phase == EPIL_BUS_IDLE
            |=> !pready ##1 pready;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("apb answer not after one wait cycle");

    property p_break_permit;
        !s.mode && wr_ctrl && pwdata[EPIL_BIT_ACK] && break_state
            && break_clear_permit_bit && !pin.fall |=> !s.latch;
    endproperty
    a_break_permit: assert property (p_break_permit) // R15
        else $error("permitted break ack did not clear latch");

    property p_ack_remembered;
        s.mode && sw_ack && !pin.fall |=> s.ack_seen || !s.latch;
    endproperty
    a_ack_remembered: assert property (p_ack_remembered) // R3 R7
        else $error("level mode ack not remembered");

    property p_irq_level;
        irq == |(s.ev_stat & s.ev_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq does not follow status and mask");

    property p_stat_sticky;
        s.ev_stat[EPIL_EV_SET] && !wr_stat |=> s.ev_stat[EPIL_EV_SET];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("event status bit lost without a clear");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");

    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");

    property p_ctrl_hold;
        !wr_ctrl |=> $stable(s.mode) && $stable(s.mask);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("mode or mask changed without a write");

    c_edge_req: cover property (!s.mode && pin.fall ##1 s.latch);
    c_level_ack_first: cover property (s.mode && s.latch && ack
                                       && !pin.level);
    c_break_block: cover property (break_state && wr_ctrl
                                   && pwdata[EPIL_BIT_ACK]);
    c_irq_out: cover property (!irq ##1 irq);
    c_fetch_clear: cover property (vector_fetch && s.latch ##1 !s.latch);

endmodule : epil_top

`default_nettype wire
